// >>> logic/oms_top.sv
// key-authorised operating mode selector with AHB-Lite registers
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

// Operation
// - three modes; button one primary or service by hold, button two secondary
// - each mode owns one output, driven to 1 on valid selection
// - at most one mode output is high at any time
// - storage setting restarts in last selected mode, lamps and output
// - other settings restart in primary mode, button one lit
// - mode changes only with a key present; else outputs unchanged
// - class 01 primary; class 02 adds secondary; service class all
// - switch sampled at start-up, adopted only if valid, else fault
// - switch compared with adopted value while running; change means fault
// - only eight settings valid; any other pattern means fault
// - settings 1-4 basic download, 5-8 advanced with lock
// - 1/5 hold plus service fallback, 2/6 hold, 3/7 fallback, 4/8 storage
// - hold or storage keep mode, lamps and output on key removal
// - fallback, or service fallback in service, reverts to primary
// - selected mode shown by its lamp; service flashes all lamps
// - button one hold length picks primary or service
// - holds beyond 5 s normal or 10 s service flag misuse
// - presses under 50 ms are ignored entirely
module oms_top #(
  parameter int unsigned TICK_CYC   = oms_pkg::TICK_CYC,
  parameter int unsigned T_MIN      = oms_pkg::T_MIN_MS,
  parameter int unsigned T_SVC_HOLD = oms_pkg::T_SVC_HOLD_MS,
  parameter int unsigned T_NORM_MAX = oms_pkg::T_NORM_MAX_MS,
  parameter int unsigned T_SVC_MAX  = oms_pkg::T_SVC_MAX_MS,
  parameter int unsigned T_FLASH    = oms_pkg::T_FLASH_MS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // operator side pins
  input  wire logic        btn1_in,
  input  wire logic        btn2_in,
  input  wire logic        key_present_in,
  input  wire logic [1:0]  key_class_in,
  input  wire logic [3:0]  cfg_sw_in,
  input  wire logic [1:0]  stored_mode_in,
  // mode outputs
  output logic             primary_mode_out,
  output logic             secondary_mode_out,
  output logic             service_mode_out,
  output logic             unused_mode_out_a,
  output logic             unused_mode_out_b,
  // lamps, storage and download mode
  output logic             led_btn1_out,
  output logic             led_btn2_out,
  output oms_pkg::oms_mode_t stored_mode_out,
  output logic             adv_download_out
);
  import oms_pkg::*;

  localparam logic [DW-1:0] TICK_LAST  = DW'(TICK_CYC - 1);
  localparam logic [TW-1:0] FLASH_LAST = TW'(T_FLASH - 1);
  localparam logic [3:0]    START_LAST = 4'(START_CYC - 1);

  typedef enum logic [1:0] {S_START, S_RUN, S_FAULT} oms_state_t;

  function automatic logic cfg_ok(input logic [3:0] c);
    cfg_ok = (c >= CFG_FIRST) && (c <= CFG_LAST);
  endfunction : cfg_ok

  function automatic oms_beh_t beh_of(input logic [3:0] c);
    logic [3:0] idx;
    idx    = c - CFG_FIRST;
    beh_of = oms_beh_t'(idx[1:0]);
  endfunction : beh_of

  function automatic logic adv_of(input logic [3:0] c);
    logic [3:0] idx;
    idx    = c - CFG_FIRST;
    adv_of = idx[2];
  endfunction : adv_of

  function automatic logic allowed(input logic [1:0] k,
                                   input oms_mode_t  m);
    case (k)
      KEY_CLASS_1:   allowed = (m == MODE_PRIMARY);
      KEY_CLASS_2:   allowed = (m != MODE_SERVICE);
      KEY_CLASS_SVC: allowed = 1'b1;
      default:       allowed = 1'b0;
    endcase
  endfunction : allowed

  // pin synchronisation
  logic       btn1_s, btn2_s, key_s;
  logic [1:0] class_s, stored_s;
  logic [3:0] cfg_s;

  oms_sync #(.W(11)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    ({btn1_in, btn2_in, key_present_in, key_class_in,
               cfg_sw_in, stored_mode_in}),
    .q_out   ({btn1_s, btn2_s, key_s, class_s, cfg_s, stored_s})
  );

  // 1 ms tick and lamp flash rate
  logic [DW-1:0] tick_cnt_reg, tick_cnt_next;
  logic          tick_reg, tick_next;
  logic [TW-1:0] fl_cnt_reg, fl_cnt_next;
  logic          flash_reg, flash_next;

  always_comb begin
    tick_cnt_next = tick_cnt_reg + 1'b1;
    tick_next     = 1'b0;
    fl_cnt_next   = fl_cnt_reg;
    flash_next    = flash_reg;
    if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_next = '0;
      tick_next     = 1'b1;
    end
    if (tick_reg) begin
      fl_cnt_next = fl_cnt_reg + 1'b1;
      if (fl_cnt_reg == FLASH_LAST) begin
        fl_cnt_next = '0;
        flash_next  = !flash_reg;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      fl_cnt_reg   <= '0;
      flash_reg    <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
      fl_cnt_reg   <= fl_cnt_next;
      flash_reg    <= flash_next;
    end
  end

  // pushbutton timing
  oms_btn_if evt ();

  oms_btn_timer #(
    .T_MIN      (T_MIN),
    .T_SVC_HOLD (T_SVC_HOLD),
    .T_NORM_MAX (T_NORM_MAX),
    .T_SVC_MAX  (T_SVC_MAX)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_reg),
    .btn1    (btn1_s),
    .btn2    (btn2_s),
    .evt     (evt.timer)
  );

  // ahb-lite register slave, zero wait states
  logic        wr_pend_reg, wr_pend_next;
  logic [11:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        lock_reg, lock_next;
  logic [2:0]  flags_clr;
  logic        ap_take;

  oms_state_t  st_reg, st_next;
  oms_mode_t   mode_reg, mode_next;
  logic [3:0]  cfg_reg, cfg_next;
  logic [2:0]  flags_reg, flags_next;

  assign ap_take = hsel && hready && htrans[1];

  always_comb begin
    wr_pend_next = ap_take && hwrite;
    wr_addr_next = haddr[11:0];
    rdata_next   = rdata_reg;
    lock_next    = lock_reg;
    flags_clr    = 3'h0;
    if (ap_take && !hwrite) begin
      rdata_next = 32'h0;
      if (haddr[11:0] == ADDR_STATUS) begin
        rdata_next[ST_MODE_LSB +: 2]  = mode_reg;
        rdata_next[ST_FAULT_BIT]      = (st_reg == S_FAULT);
        rdata_next[ST_KEY_BIT]        = key_s;
        rdata_next[ST_CLASS_LSB +: 2] = class_s;
        rdata_next[ST_CFG_LSB +: 4]   = cfg_reg;
        rdata_next[ST_ADV_BIT]        = adv_download_out;
      end else if (haddr[11:0] == ADDR_FLAGS) begin
        rdata_next[2:0] = flags_reg;
      end else if (haddr[11:0] == ADDR_CTRL) begin
        rdata_next[CTRL_LOCK_BIT] = lock_reg;
      end
    end
    if (wr_pend_reg) begin
      if (wr_addr_reg == ADDR_FLAGS) begin
        flags_clr = hwdata[2:0];
      end else if (wr_addr_reg == ADDR_CTRL) begin
        lock_next = hwdata[CTRL_LOCK_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      rdata_reg   <= 32'h0;
      lock_reg    <= LOCK_RESET;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
      lock_reg    <= lock_next;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  assign hrdata = rdata_reg;

  // mode controller
  logic [3:0] start_reg, start_next;
  logic       key_d_reg;
  oms_mode_t  req;
  oms_beh_t   beh;
  logic       any_sel, set_noauth, set_dev, run_n, svc_n;
  logic [7:0] out_next;

  always_comb begin
    st_next    = st_reg;
    mode_next  = mode_reg;
    cfg_next   = cfg_reg;
    start_next = start_reg;
    set_noauth = 1'b0;
    set_dev    = 1'b0;
    beh        = beh_of(cfg_reg);
    any_sel    = evt.sel_primary || evt.sel_secondary || evt.sel_service;
    req        = evt.sel_service   ? MODE_SERVICE :
                 evt.sel_secondary ? MODE_SECONDARY : MODE_PRIMARY;
    case (st_reg)
      S_START: begin
        // let the synchroniser settle before sampling the switch
        if (start_reg != START_LAST) begin
          start_next = start_reg + 1'b1;
        end else if (cfg_ok(cfg_s)) begin
          cfg_next = cfg_s;
          st_next  = S_RUN;
          if (beh_of(cfg_s) == BEH_STORAGE &&
              stored_s != MODE_NONE) begin
            mode_next = oms_mode_t'(stored_s);
          end else begin
            mode_next = MODE_PRIMARY;
          end
        end else begin
          st_next = S_FAULT;
        end
      end
      S_RUN: begin
        if (cfg_s != cfg_reg) begin
          st_next   = S_FAULT;
          mode_next = MODE_NONE;
        end else if (key_d_reg && !key_s) begin
          // hold and storage keep the mode as it is
          if (beh == BEH_FALLBACK ||
              (beh == BEH_HOLD_SVC_FB && mode_reg == MODE_SERVICE)) begin
            mode_next = MODE_PRIMARY;
          end
        end else if (any_sel) begin
          if (key_s && allowed(class_s, req) &&
              !(lock_reg && adv_of(cfg_reg))) begin
            mode_next = req;
          end else begin
            set_noauth = 1'b1;
          end
        end
      end
      default: begin
        // only a reset on hresetn leaves the fault state
        st_next   = S_FAULT;
        mode_next = MODE_NONE;
        set_dev   = 1'b1;
      end
    endcase
    // event set wins over a software clear in the same cycle
    flags_next = (flags_reg & ~flags_clr) |
                 {set_dev, evt.err_incorrect, set_noauth};
    run_n = (st_next == S_RUN);
    svc_n = run_n && mode_next == MODE_SERVICE;
    // single mode encoding keeps the outputs one-hot
    out_next[0] = run_n && mode_next == MODE_PRIMARY;
    out_next[1] = run_n && mode_next == MODE_SECONDARY;
    out_next[2] = svc_n;
    out_next[3] = out_next[0] || (svc_n && flash_next);
    out_next[4] = out_next[1] || (svc_n && flash_next);
    out_next[5] = run_n && adv_of(cfg_next);
    out_next[7:6] = run_n ? mode_next : MODE_NONE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg             <= S_START;
      mode_reg           <= MODE_NONE;
      cfg_reg            <= 4'h0;
      start_reg          <= 4'h0;
      key_d_reg          <= 1'b0;
      flags_reg          <= FLAGS_RESET;
      primary_mode_out   <= 1'b0;
      secondary_mode_out <= 1'b0;
      service_mode_out   <= 1'b0;
      unused_mode_out_a  <= 1'b0;
      unused_mode_out_b  <= 1'b0;
      led_btn1_out       <= 1'b0;
      led_btn2_out       <= 1'b0;
      adv_download_out   <= 1'b0;
      stored_mode_out    <= MODE_NONE;
    end else begin
      st_reg             <= st_next;
      mode_reg           <= mode_next;
      cfg_reg            <= cfg_next;
      start_reg          <= start_next;
      key_d_reg          <= key_s;
      flags_reg          <= flags_next;
      primary_mode_out   <= out_next[0];
      secondary_mode_out <= out_next[1];
      service_mode_out   <= out_next[2];
      unused_mode_out_a  <= 1'b0;
      unused_mode_out_b  <= 1'b0;
      led_btn1_out       <= out_next[3];
      led_btn2_out       <= out_next[4];
      adv_download_out   <= out_next[5];
      stored_mode_out    <= oms_mode_t'(out_next[7:6]);
    end
  end
endmodule : oms_top

// >>> logic/oms_pkg.sv
// shared constants and types of the operating mode selector
package oms_pkg;
  // clock and derived timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_HZ       = 1000;
  localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;
  localparam int unsigned T_MIN_MS      = 50;
  localparam int unsigned T_NORM_MAX_MS = 5000;
  localparam int unsigned T_SVC_MAX_MS  = 10000;
  localparam int unsigned T_SVC_HOLD_MS = 2000;
  localparam int unsigned T_FLASH_MS    = 250;
  localparam int unsigned START_CYC     = 8;
  localparam int          TW            = 14;
  localparam int          DW            = 16;

  // key classes and configuration switch settings
  localparam logic [1:0] KEY_CLASS_1   = 2'h1;
  localparam logic [1:0] KEY_CLASS_2   = 2'h2;
  localparam logic [1:0] KEY_CLASS_SVC = 2'h3;
  localparam logic [3:0] CFG_FIRST     = 4'h1;
  localparam logic [3:0] CFG_LAST      = 4'h8;

  // register map, byte offsets
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_FLAGS  = 12'h004;
  localparam logic [11:0] ADDR_CTRL   = 12'h008;

  // field positions
  localparam int ST_MODE_LSB   = 0;
  localparam int ST_FAULT_BIT  = 2;
  localparam int ST_KEY_BIT    = 3;
  localparam int ST_CLASS_LSB  = 4;
  localparam int ST_CFG_LSB    = 8;
  localparam int ST_ADV_BIT    = 12;
  localparam int FLG_NOAUTH    = 0;
  localparam int FLG_INCORRECT = 1;
  localparam int FLG_DEVERR    = 2;
  localparam int CTRL_LOCK_BIT = 0;

  // reset values
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic       LOCK_RESET  = 1'b0;

  typedef enum logic [1:0] {
    MODE_PRIMARY, MODE_SECONDARY, MODE_SERVICE, MODE_NONE
  } oms_mode_t;

  typedef enum logic [1:0] {
    BEH_HOLD_SVC_FB, BEH_HOLD, BEH_FALLBACK, BEH_STORAGE
  } oms_beh_t;
endpackage : oms_pkg

// >>> logic/oms_btn_if.sv
// selection events from the pushbutton timer to the mode controller
`timescale 1ns/1ps
interface oms_btn_if;
  logic sel_primary;
  logic sel_secondary;
  logic sel_service;
  logic err_incorrect;
  modport timer (
    output sel_primary, sel_secondary, sel_service, err_incorrect
  );
  modport ctrl (
    input sel_primary, sel_secondary, sel_service, err_incorrect
  );
endinterface : oms_btn_if

// >>> logic/oms_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module oms_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // raw pins in, filtered levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // stage one is looked at by stage two only
  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) q_next[i] = s3_reg[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_out = q_reg;
endmodule : oms_sync

// >>> logic/oms_btn_timer.sv
// pushbutton hold timer: turns presses into selection or error events
`timescale 1ns/1ps
module oms_btn_timer #(
  parameter int unsigned T_MIN      = oms_pkg::T_MIN_MS,
  parameter int unsigned T_SVC_HOLD = oms_pkg::T_SVC_HOLD_MS,
  parameter int unsigned T_NORM_MAX = oms_pkg::T_NORM_MAX_MS,
  parameter int unsigned T_SVC_MAX  = oms_pkg::T_SVC_MAX_MS
) (
  // clock, reset and 1 ms enable
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tick,
  // filtered buttons
  input  wire logic btn1,
  input  wire logic btn2,
  // events
  oms_btn_if.timer  evt
);
  import oms_pkg::*;

  localparam logic [TW-1:0] LIM_MIN  = TW'(T_MIN);
  localparam logic [TW-1:0] LIM_SVC  = TW'(T_SVC_HOLD);
  localparam logic [TW-1:0] LIM_NORM = TW'(T_NORM_MAX);
  localparam logic [TW-1:0] LIM_SMAX = TW'(T_SVC_MAX);

  typedef enum logic [1:0] {TS_IDLE, TS_HELD, TS_WAIT} oms_tstate_t;

  oms_tstate_t   st_reg, st_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  logic          one_reg, one_next;
  logic [3:0]    ev_reg, ev_next;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    one_next = one_reg;
    ev_next  = 4'h0;
    case (st_reg)
      TS_IDLE: begin
        if (btn1 && btn2) begin
          st_next = TS_WAIT;
        end else if (btn1 || btn2) begin
          st_next  = TS_HELD;
          cnt_next = '0;
          one_next = btn1;
        end
      end
      TS_HELD: begin
        if (tick && cnt_reg != '1) cnt_next = cnt_reg + 1'b1;
        if (btn1 && btn2) begin
          ev_next[3] = 1'b1;
          st_next    = TS_WAIT;
        end else if (one_reg ? !btn1 : !btn2) begin
          st_next = TS_IDLE;
          // short presses leave no trace at all
          if (cnt_reg >= LIM_MIN) begin
            if (!one_reg) ev_next[1] = 1'b1;
            else if (cnt_reg >= LIM_SVC) ev_next[2] = 1'b1;
            else ev_next[0] = 1'b1;
          end
        end else if (cnt_reg > (one_reg ? LIM_SMAX : LIM_NORM)) begin
          ev_next[3] = 1'b1;
          st_next    = TS_WAIT;
        end
      end
      TS_WAIT: begin
        if (!btn1 && !btn2) st_next = TS_IDLE;
      end
      default: st_next = TS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg  <= TS_IDLE;
      cnt_reg <= '0;
      one_reg <= 1'b0;
      ev_reg  <= 4'h0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      one_reg <= one_next;
      ev_reg  <= ev_next;
    end
  end

  assign evt.sel_primary   = ev_reg[0];
  assign evt.sel_secondary = ev_reg[1];
  assign evt.sel_service   = ev_reg[2];
  assign evt.err_incorrect = ev_reg[3];
endmodule : oms_btn_timer

// >>> test/oms_chk.sv
// port-level assertions for the operating mode selector
`timescale 1ns/1ps
module oms_chk
  import oms_pkg::*;
(
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // operator side
  input wire logic       key_present_in,
  input wire logic [3:0] cfg_sw_in,
  // mode outputs and lamps
  input wire logic       primary_mode_out,
  input wire logic       secondary_mode_out,
  input wire logic       service_mode_out,
  input wire logic       unused_mode_out_a,
  input wire logic       unused_mode_out_b,
  input wire logic       led_btn1_out,
  input wire logic       led_btn2_out,
  input oms_mode_t       stored_mode_out,
  input wire logic       adv_download_out
);
  import oms_pkg::*;
  logic [4:0] nokey_cnt;
  logic [4:0] cfg_cnt;
  wire logic any_mode = primary_mode_out | secondary_mode_out
                        | service_mode_out;
  wire logic cfg_ok = (cfg_sw_in >= 4'h1) && (cfg_sw_in <= 4'h8);
  wire logic cfg_adv = (cfg_sw_in >= 4'h5) && (cfg_sw_in <= 4'h8);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // counters give the synchronisers time before judging
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nokey_cnt <= 5'h00;
      cfg_cnt   <= 5'h00;
    end else begin
      nokey_cnt <= key_present_in ? 5'h00 :
                   (nokey_cnt == 5'h1f ? nokey_cnt : nokey_cnt + 5'h01);
      cfg_cnt   <= $changed(cfg_sw_in) ? 5'h00 :
                   (cfg_cnt == 5'h1f ? cfg_cnt : cfg_cnt + 5'h01);
    end
  end
  sequence s_settle;
    ##[6:16] any_mode;
  endsequence
  sequence s_dark;
    (!any_mode)[*8];
  endsequence
  AST_ONE_HOT: assert property (
    $onehot0({primary_mode_out, secondary_mode_out, service_mode_out}))
    else $error("more than one mode output high");
  AST_UNUSED: assert property (
    !unused_mode_out_a && !unused_mode_out_b)
    else $error("unused mode output driven");
  AST_START_OK: assert property (
    $rose(hresetn) && cfg_ok |-> s_settle)
    else $error("no mode after start with valid setting");
  AST_START_BAD: assert property (
    $rose(hresetn) && !cfg_ok |-> s_dark)
    else $error("mode output with invalid setting");
  AST_NO_KEY: assert property (
    nokey_cnt >= 5'h10 && cfg_cnt >= 5'h10 |=> $stable({primary_mode_out,
      secondary_mode_out, service_mode_out}))
    else $error("mode changed without key");
  AST_CFG_CHANGE: assert property (
    $changed(cfg_sw_in) && any_mode |-> ##[1:10] !any_mode)
    else $error("setting change not turned into fault");
  AST_ADV: assert property (
    cfg_cnt >= 5'h0c && any_mode |-> adv_download_out == cfg_adv)
    else $error("download mode does not follow setting");
  AST_PRI_LAMP: assert property (
    primary_mode_out[*3] |-> led_btn1_out && !led_btn2_out)
    else $error("primary lamp wrong");
  AST_SVC_FLASH: assert property (
    service_mode_out[*3] |-> led_btn1_out == led_btn2_out)
    else $error("service lamps not flashing together");
  AST_STORED: assert property (
    any_mode[*2] |-> stored_mode_out == (secondary_mode_out ?
      MODE_SECONDARY : (service_mode_out ? MODE_SERVICE : MODE_PRIMARY)))
    else $error("stored mode differs from active mode");
endmodule : oms_chk
bind oms_top oms_chk u_oms_chk (.hclk(hclk), .hresetn(hresetn),
  .key_present_in(key_present_in), .cfg_sw_in(cfg_sw_in),
  .primary_mode_out(primary_mode_out),
  .secondary_mode_out(secondary_mode_out),
  .service_mode_out(service_mode_out),
  .unused_mode_out_a(unused_mode_out_a),
  .unused_mode_out_b(unused_mode_out_b), .led_btn1_out(led_btn1_out),
  .led_btn2_out(led_btn2_out), .stored_mode_out(stored_mode_out),
  .adv_download_out(adv_download_out));

// >>> test/oms_panel.sv
// operator panel model: presses one pushbutton for a set time
`timescale 1ns/1ps
module oms_panel (
  // clock
  input  wire logic       hclk,
  // press request
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [7:0] len,
  // pushbutton pins, released to the pull-down level
  output logic            btn1,
  output logic            btn2
);
  logic [7:0] cnt_reg = 8'h00;
  logic       sel_reg = 1'b0;
  // one button at a time; a new request restarts the press
  always @(posedge hclk) begin
    if (go) begin
      cnt_reg <= len;
      sel_reg <= sel;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign btn1 = (cnt_reg != 8'h00) && !sel_reg;
  assign btn2 = (cnt_reg != 8'h00) && sel_reg;
endmodule : oms_panel

// >>> test/oms_top_tb.sv
// self-checking bench of the operating mode selector
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module oms_top_tb;
  import oms_pkg::*;
  typedef struct packed {
    logic [1:0] k;
    logic       b;
    logic [7:0] len;
    logic [1:0] m;
  } oms_row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  logic [1:0]  htrans = 2'h0, key_class_in = 2'h0, stored_mode_in = 2'h3;
  logic [3:0]  cfg_sw_in = 4'h2;
  logic key_present_in = 1'b0, go = 1'b0, sel = 1'b0;
  logic [7:0]  len = 8'h00;
  logic hreadyout, hresp, btn1, btn2, p_out, s_out, v_out;
  logic led1, led2, un_a, un_b, adv;
  oms_mode_t stm;
  logic [31:0] hrdata;
  wire logic [2:0] outs = {p_out, s_out, v_out};
  int mismatches = 0, n_checks = 0;
  // class, button (1 = two), press cycles, expected mode after
  oms_row_t rows [10] = '{'{2'h1, 1'b1, 8'h23, 2'h0},
    '{2'h2, 1'b1, 8'h23, 2'h1}, '{2'h2, 1'b0, 8'h50, 2'h1},
    '{2'h3, 1'b0, 8'h50, 2'h2}, '{2'h3, 1'b0, 8'h23, 2'h0},
    '{2'h3, 1'b1, 8'h0a, 2'h0}, '{2'h3, 1'b1, 8'h6e, 2'h0},
    '{2'h3, 1'b1, 8'h23, 2'h1}, '{2'h1, 1'b0, 8'h23, 2'h0},
    '{2'h3, 1'b0, 8'h50, 2'h2}};
  // sim timing: 10 cycle tick, 2/5/8/12 tick thresholds
  oms_top #(.TICK_CYC(10), .T_MIN(2), .T_SVC_HOLD(5), .T_NORM_MAX(8),
    .T_SVC_MAX(12), .T_FLASH(2)) u_oms_top (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .btn1_in(btn1),
    .btn2_in(btn2), .key_present_in(key_present_in),
    .key_class_in(key_class_in), .cfg_sw_in(cfg_sw_in),
    .stored_mode_in(stored_mode_in), .primary_mode_out(p_out),
    .secondary_mode_out(s_out), .service_mode_out(v_out),
    .unused_mode_out_a(un_a), .unused_mode_out_b(un_b),
    .led_btn1_out(led1), .led_btn2_out(led2), .stored_mode_out(stm),
    .adv_download_out(adv));
  oms_panel u_oms_panel (.hclk(hclk), .go(go), .sel(sel), .len(len),
    .btn1(btn1), .btn2(btn2));
  initial begin
    forever #10 hclk = ~hclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // one single ahb transfer; waits on hready at both phases
  task automatic ahb(input logic w, input logic [31:0] a, d);
    int i;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    for (i = 0; i < 2; i++) begin : ph
      int t;
      t = 0;
      do begin
        @(posedge hclk);
        t++;
      end while (hreadyout !== 1'b1 && t < 50);
      if (t >= 50) begin
        mismatches++;
        end_sim;
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
    end
    r = hrdata;
  endtask : ahb
  task automatic start(input logic [3:0] c, input logic [1:0] s);
    hresetn <= 1'b0;
    cfg_sw_in <= c;
    stored_mode_in <= s;
    key_present_in <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
  endtask : start
  // result shows ~6 cycles after release; 20 leaves margin
  task automatic press(input logic b, input logic [7:0] n);
    go <= 1'b1;
    sel <= b;
    len <= n;
    @(posedge hclk);
    go <= 1'b0;
    repeat (int'(n) + 20) @(posedge hclk);
  endtask : press
  initial begin
    repeat (90000) @(posedge hclk);
    mismatches++;
    end_sim;
  end
  initial begin
    start(4'h2, 2'h2);
    `CHK(outs, 3'h4)
    `CHK({led1, led2}, 2'h2)
    `CHK({un_a, un_b, stm}, {2'h0, MODE_PRIMARY})
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(r[12:0], 13'h0200)
    press(1'b1, 8'h23);
    `CHK(outs, 3'h4)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(r[2:0], 3'h1)
    ahb(1'b1, 32'h4, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(r[2:0], 3'h0)
    ahb(1'b0, 32'hc, 32'h0);
    `CHK(r, 32'h0)
    key_present_in <= 1'b1;
    foreach (rows[i]) begin
      key_class_in <= rows[i].k;
      press(rows[i].b, rows[i].len);
      `CHK(outs, 3'h4 >> rows[i].m)
    end
    key_present_in <= 1'b0;
    repeat (20) @(posedge hclk);
    `CHK(outs, 3'h1)
    // setting, button, press, mode left after key removal
    for (int j = 0; j < 4; j++) begin
      start(j == 0 ? 4'h3 : (j == 3 ? 4'h4 : 4'h1), 2'h3);
      key_present_in <= 1'b1;
      key_class_in <= 2'h3;
      press(j > 1, j > 1 ? 8'h23 : 8'h50);
      key_present_in <= 1'b0;
      repeat (20) @(posedge hclk);
      `CHK(outs, j > 1 ? 3'h2 : 3'h4)
    end
    start(4'h8, 2'h2);
    `CHK(outs, 3'h1)
    `CHK({adv, stm}, {1'b1, MODE_SERVICE})
    ahb(1'b0, 32'h0, 32'h0);
    `CHK(r[12], 1'b1)
    // mode lock refuses even a fully authorised key
    key_present_in <= 1'b1;
    key_class_in <= 2'h3;
    ahb(1'b1, 32'h8, 32'h1);
    ahb(1'b0, 32'h8, 32'h0);
    `CHK(r[0], 1'b1)
    press(1'b1, 8'h23);
    `CHK(outs, 3'h1)
    key_present_in <= 1'b0;
    cfg_sw_in <= 4'h7;
    repeat (20) @(posedge hclk);
    `CHK(outs, 3'h0)
    cfg_sw_in <= 4'h8;
    repeat (20) @(posedge hclk);
    `CHK(outs, 3'h0)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(r[2], 1'b1)
    foreach (rows[i]) if (i < 3) begin
      start(i == 0 ? 4'h0 : (i == 1 ? 4'h9 : 4'hf), 2'h0);
      `CHK(outs, 3'h0)
    end
    end_sim;
  end
endmodule : oms_top_tb
